// file: hw/lrc_top.sv
// Module: AHB-Lite slave holding the ladder reference control register
//
// Contract
// - Two ranges, each with a 4-bit level code picking one of 16 taps.
// - Range select at control bit 5 chooses between the two ranges.
// - Low range (select 1) gives level/24 of the supply.
// - High range (select 0) gives quarter supply plus level/32 of supply.
// - Supply comes from device rails or external reference pins, per bit 4.
// - Ladder powers down while the enable bit is clear.
// - Reset clears enable (bit 7) and pin output enable (bit 6).
// - Reset clears range select and all four level bits.
// - Output reaches port pin only with direction bit and output enable both set.
// - Wake from sleep leaves the control register unchanged.
// - Reference works regardless of comparator mode.
// - Comparators see the reference only in comparator mode 110.
`timescale 1ns/1ns
module lrc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic port_a2_direction_bit,
   input wire logic [2:0] comparator_mode_code,
   input wire logic sleep_wake,
   output logic ladder_power_enable,
   output logic ladder_pin_output_enable,
   output logic ladder_range_select,
   output logic ladder_source_select,
   output logic [3:0] ladder_level_code,
   output lrc_pkg::lrc_ladder_t ladder_switches
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      lrc_pkg::lrc_ctrl_t ctrl;
      logic wr_pend;
      logic [11:0] addr;
      logic [31:0] rdata;
   } lrc_state_t;
   lrc_state_t state_r;
   lrc_state_t state_nxt;
   logic access;
   lrc_pkg::lrc_ladder_t ladder_w;

   // Word address decode used for both read and write paths
   function automatic logic hits(input logic [11:0] a, input logic [11:0] off);
      hits = (a[11:2] == off[11:2]);
   endfunction

   // Only NONSEQ/SEQ transfers with the bus ready count
   assign access = hsel & hready & htrans[1];

   // Bus handling; write data lands in the data phase, so the register
   // updates at the edge that completes the write (zero wait states)
   always_comb begin
      state_nxt = state_r;
      state_nxt.wr_pend = access & hwrite;
      if (access) begin
         state_nxt.addr = haddr;
      end
      if (state_r.wr_pend && hits(state_r.addr, lrc_pkg::LRC_CTRL_OFFSET)) begin
         state_nxt.ctrl = lrc_pkg::lrc_ctrl_t'(hwdata[7:0]);
      end
      // Read data is captured in the address phase so hrdata is a flop
      state_nxt.rdata = '0;
      if (access && !hwrite) begin
         if (hits(haddr, lrc_pkg::LRC_CTRL_OFFSET)) begin
            state_nxt.rdata = {24'h0, state_nxt.ctrl};
         end else if (hits(haddr, lrc_pkg::LRC_STATUS_OFFSET)) begin
            state_nxt.rdata = {22'h0, ladder_w.ladder_on, ladder_w.pin_connect,
                               ladder_w.cmp_ref_connect, ladder_w.supply_ext, ladder_w.range_low,
                               ladder_w.tap[4:0]};
         end
      end
      // Wake from sleep deliberately has no term here: the register keeps its value
   end

   // Register; async reset gives all-zero control
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r.ctrl <= lrc_pkg::LRC_CTRL_RESET;
         state_r.wr_pend <= 1'b0;
         state_r.addr <= 12'h000;
         state_r.rdata <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************************************
   // Ladder decode
   // ****************************************************************
   lrc_tap_decode u_dec (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctrl(state_r.ctrl),
      .port_a2_direction_bit(port_a2_direction_bit),
      .comparator_mode_code(comparator_mode_code),
      .ladder(ladder_w)
   );

   // Outputs straight from flops; back-to-back read after write sees new value
   assign hrdata = state_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign ladder_power_enable = state_r.ctrl.power_en;
   assign ladder_pin_output_enable = state_r.ctrl.pin_oe;
   assign ladder_range_select = state_r.ctrl.range_low;
   assign ladder_source_select = state_r.ctrl.source_ext;
   assign ladder_level_code = state_r.ctrl.level;
   assign ladder_switches = ladder_w;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   AST_WRITE_TAKES: assert property (@(posedge hclk) disable iff (!hresetn)
      (access && hwrite && haddr[11:2] == 10'h000) ##1 1'b1 |=>
      ladder_level_code == $past(hwdata[3:0]) && ladder_power_enable == $past(hwdata[7]))
      else $error("control write not applied");
   AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      !state_r.wr_pend |=> $stable(state_r.ctrl))
      else $error("control changed without write");
   AST_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
      sleep_wake && !state_r.wr_pend |=> $stable(state_r.ctrl))
      else $error("wake altered control");
   AST_READBACK: assert property (@(posedge hclk) disable iff (!hresetn)
      (access && !hwrite && haddr[11:2] == 10'h000 && !state_r.wr_pend) |=>
      hrdata == {24'h0, $past(state_r.ctrl)})
      else $error("readback mismatch");
   AST_UNMAPPED: assert property (@(posedge hclk) disable iff (!hresetn)
      (access && !hwrite && haddr[11:3] != 9'h000) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_POWER_FOLLOW: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 ladder_switches.ladder_on == $past(ladder_power_enable))
      else $error("ladder power not following enable");
   AST_SOURCE: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 ladder_switches.supply_ext == $past(ladder_source_select))
      else $error("supply selection wrong");
   AST_RESET_ZERO: assert property (@(posedge hclk)
      $rose(hresetn) |-> state_r.ctrl == 8'h00)
      else $error("control not cleared by reset");
   COV_WRITE: cover property (@(posedge hclk) disable iff (!hresetn) access && hwrite);
   COV_PIN: cover property (@(posedge hclk) disable iff (!hresetn) ladder_switches.pin_connect);
   COV_LOW: cover property (@(posedge hclk) disable iff (!hresetn) ladder_switches.range_low && ladder_switches.ladder_on);
endmodule

// file: pkg/lrc_pkg.sv
// Package: register map, field layout and control types for the ladder reference control
package lrc_pkg;
   // ****************************************************************
   // Register map and fields
   // ****************************************************************
   localparam logic [11:0] LRC_CTRL_OFFSET = 12'h000;
   localparam logic [11:0] LRC_STATUS_OFFSET = 12'h004;
   localparam logic [7:0] LRC_CTRL_RESET = 8'h00;
   localparam int LRC_BIT_POWER_EN = 7;
   localparam int LRC_BIT_PIN_OE = 6;
   localparam int LRC_BIT_RANGE = 5;
   localparam int LRC_BIT_SOURCE = 4;
   localparam int LRC_LEVEL_MSB = 3;
   localparam int LRC_TAP_COUNT = 16;
   localparam int LRC_LOW_DIV = 24;
   localparam int LRC_HIGH_DIV = 32;
   localparam int LRC_HIGH_BASE_TAPS = 8;
   localparam logic [2:0] LRC_CMP_MUX4 = 3'h6;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic power_en;
      logic pin_oe;
      logic range_low;
      logic source_ext;
      logic [3:0] level;
   } lrc_ctrl_t;

   typedef struct packed {
      logic ladder_on;
      logic pin_connect;
      logic cmp_ref_connect;
      logic supply_ext;
      logic range_low;
      logic [5:0] tap;
      logic [5:0] divisor;
   } lrc_ladder_t;
endpackage

// file: hw/lrc_tap_decode.sv
// Module: ladder tap decoder that turns the control fields into analogue switch settings
`timescale 1ns/1ns
module lrc_tap_decode (
   input wire logic hclk,
   input wire logic hresetn,
   input wire lrc_pkg::lrc_ctrl_t ctrl,
   input wire logic port_a2_direction_bit,
   input wire logic [2:0] comparator_mode_code,
   output lrc_pkg::lrc_ladder_t ladder
);
   typedef struct packed {
      lrc_pkg::lrc_ladder_t ladder;
   } lrc_dec_state_t;
   lrc_dec_state_t state_r;
   lrc_dec_state_t state_nxt;

   // Reset image is the decode of an all-zero control word: high range, tap 8 over 32.
   // Keeps the tap checks true on the first edge after release.
   localparam lrc_pkg::lrc_ladder_t LADDER_RESET = '{ladder_on: 1'b0, pin_connect: 1'b0, cmp_ref_connect: 1'b0,
      supply_ext: 1'b0, range_low: 1'b0, tap: 6'(lrc_pkg::LRC_HIGH_BASE_TAPS), divisor: 6'(lrc_pkg::LRC_HIGH_DIV)};

   // Tap index numerator: low range is level/24, high is (8+level)/32
   function automatic logic [5:0] tap_of(input logic rng, input logic [3:0] lvl);
      if (rng) begin
         tap_of = {2'h0, lvl};
      end else begin
         tap_of = 6'(lrc_pkg::LRC_HIGH_BASE_TAPS) + {2'h0, lvl};
      end
   endfunction

   // Decode next ladder controls; pin and comparator switches follow their own enables even when powered down
   always_comb begin
      state_nxt = state_r;
      state_nxt.ladder.ladder_on = ctrl.power_en;
      state_nxt.ladder.range_low = ctrl.range_low;
      state_nxt.ladder.supply_ext = ctrl.source_ext;
      state_nxt.ladder.tap = tap_of(ctrl.range_low, ctrl.level);
      state_nxt.ladder.divisor = ctrl.range_low ? 6'(lrc_pkg::LRC_LOW_DIV) : 6'(lrc_pkg::LRC_HIGH_DIV);
      state_nxt.ladder.pin_connect = ctrl.pin_oe & port_a2_direction_bit;
      // Reference runs whatever the comparator mode; only the tie-in depends on it
      state_nxt.ladder.cmp_ref_connect = (comparator_mode_code == lrc_pkg::LRC_CMP_MUX4);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r.ladder <= LADDER_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign ladder = state_r.ladder;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   AST_PIN_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
      ladder.pin_connect |-> $past(ctrl.pin_oe) && $past(port_a2_direction_bit))
      else $error("pin connected without both enables");
   AST_TAP_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(ctrl.range_low) |-> ladder.tap == {2'h0, $past(ctrl.level)} && ladder.divisor == 6'h18)
      else $error("low range tap wrong");
   AST_TAP_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
      !$past(ctrl.range_low) |-> ladder.tap == 6'h08 + {2'h0, $past(ctrl.level)} && ladder.divisor == 6'h20)
      else $error("high range tap wrong");
   AST_CMP_MODE: assert property (@(posedge hclk) disable iff (!hresetn)
      ladder.cmp_ref_connect == ($past(comparator_mode_code) == 3'h6))
      else $error("comparator tie-in wrong");
endmodule

// file: verif/lrc_ladder_model.sv
// Behavioural model of the analogue ladder, comparator inputs and port pin
`timescale 1ns/1ns
module lrc_ladder_model #(
   parameter int RAIL_MV = 3200,
   parameter int EXT_MV = 2400
) (
   sw,
   vout_mv,
   pin_mv,
   cmp_mv
);
   input lrc_pkg::lrc_ladder_t sw;
   output logic [31:0] vout_mv;
   output logic [31:0] pin_mv;
   output logic [31:0] cmp_mv;
   logic [31:0] sup;
   // ****************************************************************
   // Ladder output
   // ****************************************************************
   // Supply choice then tap over divisor; a powered-down ladder sits at 0
   always_comb begin
      sup = sw.supply_ext ? EXT_MV : RAIL_MV;
      vout_mv = sw.ladder_on ? sw.tap * sup / sw.divisor : 32'h0;
      // A released node shows the inverse so a stale value never passes
      pin_mv = sw.pin_connect ? vout_mv : ~vout_mv;
      cmp_mv = sw.cmp_ref_connect ? vout_mv : ~vout_mv;
   end
endmodule

// file: verif/lrc_top_tb.sv
// Self-checking bench for the ladder reference control block
`timescale 1ns/1ns
module lrc_top_tb;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dir = 0, wake = 0, rd_dp = 0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, mode = 3'h0;
   logic [31:0] hwdata = 32'h0, hrdata, v, pin, cmp, exp, x;
   logic hreadyout, hresp, pe, oe, rs, ss;
   logic [3:0] lvl;
   lrc_pkg::lrc_ladder_t sw;
   logic [31:0] expq[$];
   int bad_count = 0, compares = 0, seed = 64;
   lrc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .port_a2_direction_bit(dir), .comparator_mode_code(mode), .sleep_wake(wake), .ladder_power_enable(pe),
      .ladder_pin_output_enable(oe), .ladder_range_select(rs), .ladder_source_select(ss),
      .ladder_level_code(lvl), .ladder_switches(sw));
   lrc_ladder_model model (.sw(sw), .vout_mv(v), .pin_mv(pin), .cmp_mv(cmp));
   initial begin
      forever #5 hclk = ~hclk;
   end
   // ****************************************************************
   // Checking and closing
   // ****************************************************************
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task print_verdict;
      $display("errors %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Read data is taken at the data phase end edge and checked against the oldest note
   always @(posedge hclk) begin
      if (rd_dp) chk("hrdata", expq.pop_front(), hrdata);
      if (rd_dp) chk("resp", 32'h2, {30'h0, hreadyout, hresp});
      rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
   end
   // One AHB-Lite single transfer; entered just after a rising edge
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      if (!w) expq.push_back(e);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask
   initial begin
      #200000;
      bad_count++;
      print_verdict();
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      xfer(0, 12'h000, 32'h0, 32'h0);
      xfer(0, 12'h008, 32'h0, 32'h0);
      for (int i = 0; i < 12; i++) begin
         x = $random(seed);
         if (i == 0) x[7:0] = 8'hFF;
         mode <= i[2:0];
         dir <= x[8];
         // Upper data bits are random and must be dropped
         xfer(1, 12'h000, x, 32'h0);
         xfer(0, 12'h000, 32'h0, {24'h0, x[7:0]});
         wake <= 1;
         @(posedge hclk);
         wake <= 0;
         @(posedge hclk);
         chk("fields", {24'h0, x[7:0]}, {24'h0, pe, oe, rs, ss, lvl});
         exp = x[5] ? x[3:0] * (x[4] ? 2400 : 3200) / 24 : (x[4] ? 600 + x[3:0] * 75 : 800 + x[3:0] * 100);
         chk("vout", x[7] ? exp : 32'h0, v);
         chk("pin", (x[6] && x[8]) ? v : ~v, pin);
         chk("cmp", (i[2:0] == 3'h6) ? v : ~v, cmp);
         xfer(0, 12'h004, 32'h0, {22'h0, x[7], x[6] & x[8], i[2:0] == 3'h6, x[4], x[5],
            x[5] ? {1'b0, x[3:0]} : 5'h8 + x[3:0]});
      end
      // Software drops the enable before sleeping; wake must keep the rest
      xfer(1, 12'h000, {24'h0, 1'b0, x[6:0]}, 32'h0);
      wake <= 1;
      @(posedge hclk);
      wake <= 0;
      repeat (2) @(posedge hclk);
      chk("sleep", {25'h0, x[6:0]}, {24'h0, pe, oe, rs, ss, lvl});
      chk("vout_off", 32'h0, v);
      // Two edges of reset so that past values at release are reset values
      hresetn <= 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      xfer(0, 12'h000, 32'h0, 32'h0);
      @(posedge hclk);
      print_verdict();
   end
endmodule
